// ==== design/rmc_defs.vh ====
/*
 Constants for the radio mode and acknowledged transmit controller.
 Assumes inclusion by bare name from design files; definitions only.
*/
`ifndef RMC_DEFS_VH
`define RMC_DEFS_VH

`define RMC_MODE_POWER_DOWN  3'h0
`define RMC_MODE_LOW_IDLE    3'h1
`define RMC_MODE_ARMED       3'h2
`define RMC_MODE_TRANSMIT    3'h3
`define RMC_MODE_AWAIT_ACK   3'h4
`define RMC_MODE_RECEIVE     3'h5

`define RMC_CLK_MHZ          25
`define RMC_PULSE_MIN_US     10
`define RMC_PULSE_CYC        (`RMC_PULSE_MIN_US * `RMC_CLK_MHZ)

`define RMC_FIFO_DEPTH       3
`define RMC_PIPE_COUNT       6
`define RMC_ADDR_BITS        40
`define RMC_SHARED_BITS      32
`define RMC_RETRY_BITS       4
`define RMC_LOST_BITS        4
`define RMC_SEQ_BITS         2
`define RMC_SEQ_RESET        2'h0
`define RMC_LEN_BITS         6
`define RMC_ACK_WAIT_DEF     16'h00FA

`endif

// ==== design/rmc_sync.v ====
/*
 Two-flop synchroniser for a level from outside the clock domain.
 Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module rmc_sync (
    input  wire clk,      // Clock
    input  wire arst_n,   // Async reset
    input  wire d,        // Async level
    output wire q         // Synchronised level
);
    reg meta_reg;
    reg sync_reg;
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
        end else begin
            meta_reg <= d;
            sync_reg <= meta_reg;
        end
    end
    assign q = sync_reg;
endmodule // rmc_sync
`default_nettype wire

// ==== design/rmc_ctrl.v ====
/*
 Mode controller and acknowledged transmit engine of a packet radio.
 Assumes the serial port decoder presents payload bytes, flag clears and
 channel writes as one-cycle strobes on clk; the activate pin is async.
*/
// Function
// - Mode from power, role, pin, FIFO
// - Power bit low forces power-down
// - Transmit; finish packet if pin falls
// - Pin low, idle: low idle standby
// - Configuration kept in every standby state
// - Three-entry transmit FIFO
// - Transmit FIFO usable in every mode
// - Payload length from bytes in one access
// - Add preamble, checksum; interrupt on completion
// - Pipe zero 40-bit, others share 32
// - Acknowledge with arrival pipe address
// - Auto-ack: switch to await-ack after send
// - Ack in window: flag, drop payload
// - No ack: resend if retransmit enabled
// - Over limit: flag, keep payload
// - Interrupt low while flags set; host clears
// - No sending until retry flag cleared
// - Lost count per limit; retries per packet
// - After cycle: idle, next, or armed
// - Armed goes idle when pin low
// - Channel write clears lost counter
// - Sequence id advances per loaded payload
`timescale 1ns/1ps
`default_nettype none
`include "rmc_defs.vh"
module rmc_ctrl #(
    parameter DEPTH    = `RMC_FIFO_DEPTH,
    parameter ACK_WAIT = `RMC_ACK_WAIT_DEF
) (
    input  wire        clk,                // 25 MHz clock
    input  wire        arst_n,             // Async reset
    input  wire        activate_pin,       // Activate pin, async
    input  wire        power_on_bit,       // Power-up control
    input  wire        receive_role_bit,   // Receive role control
    input  wire        pipe_zero_auto_ack, // Auto-ack on pipe zero
    input  wire [3:0]  retry_limit,        // Retry limit field
    input  wire        load_start,         // Payload access opens
    input  wire        load_byte,          // Payload byte strobe
    input  wire        load_end,           // Port select went high
    input  wire        clear_delivered,    // Status write clears delivered
    input  wire        clear_retry_limit,  // Status write clears retry limit
    input  wire        channel_write,      // Channel register written
    input  wire        send_done,          // Radio finished packet
    input  wire        ack_valid,          // Valid ack on pipe zero
    input  wire [39:0] pipe_zero_receive_address, // Ack address
    input  wire [2:0]  ack_pipe,           // Pipe of received payload
    input  wire [7:0]  pipe_low_byte,      // Low byte of that pipe
    input  wire [31:0] shared_upper,       // Shared upper bits
    output reg  [2:0]  mode_reg,           // Current mode
    output reg         send_start_reg,     // Start radio send
    output reg  [5:0]  send_len_reg,       // Payload length
    output reg  [1:0]  packet_sequence_id, // Sequence id of payload
    output reg         frame_wrap_reg,     // Add preamble and checksum
    output reg  [39:0] ack_address_reg,    // Address for acks sent
    output reg         delivered_flag,     // Delivered flag
    output reg         retry_limit_flag,   // Retry-limit flag
    output reg  [3:0]  retry_counter,      // Retries this packet
    output reg  [3:0]  lost_packet_counter,// Lost packets
    output reg  [1:0]  tx_count_reg,       // Queued payloads
    output wire        load_ready,         // FIFO has room
    output wire        irq_n               // Interrupt, active low
);
    localparam LB = `RMC_LEN_BITS;

    wire       pin_s;
    reg [15:0] wait_reg;
    reg [LB-1:0] len_mem [0:DEPTH-1];
    reg [1:0]  wr_ptr_reg;
    reg [1:0]  rd_ptr_reg;
    reg [LB-1:0] byte_cnt_reg;
    reg        loading_reg;

    rmc_sync u_pin (
        .clk    (clk),
        .arst_n (arst_n),
        .d      (activate_pin),
        .q      (pin_s)
    );

    function [1:0] ptr_inc;
        input [1:0] p;
        ptr_inc = (p == DEPTH - 1) ? 2'h0 : p + 2'h1;
    endfunction

    wire fifo_full  = (tx_count_reg == DEPTH);
    wire fifo_empty = (tx_count_reg == 2'h0);
    assign load_ready = !fifo_full;
    assign irq_n = !(delivered_flag || retry_limit_flag);

    // Pulse width not enforced: a synchronised high level starts the send
    wire pushed   = loading_reg && load_end && (byte_cnt_reg != 0) && !fifo_full;
    wire ack_ok   = (mode_reg == `RMC_MODE_AWAIT_ACK) && ack_valid;
    wire timeout  = (mode_reg == `RMC_MODE_AWAIT_ACK) && !ack_valid && (wait_reg == 16'h0000);
    wire give_up  = timeout && (retry_counter >= retry_limit);
    wire drop     = ack_ok || ((mode_reg == `RMC_MODE_TRANSMIT) && send_done && !pipe_zero_auto_ack);
    wire can_send = !fifo_empty && !retry_limit_flag;

    // Payload length from the bytes of one access
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            loading_reg  <= 1'b0;
            byte_cnt_reg <= {LB{1'b0}};
            wr_ptr_reg   <= 2'h0;
        end else begin
            if (load_start) begin
                loading_reg  <= 1'b1;
                byte_cnt_reg <= {LB{1'b0}};
            end else if (load_byte && loading_reg) begin
                byte_cnt_reg <= byte_cnt_reg + 1'b1;
            end else if (load_end) begin
                loading_reg <= 1'b0;
            end
            if (pushed)
                wr_ptr_reg <= ptr_inc(wr_ptr_reg);
        end
    end

    always @(posedge clk) begin
        if (pushed)
            len_mem[wr_ptr_reg] <= byte_cnt_reg;
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_count_reg       <= 2'h0;
            rd_ptr_reg         <= 2'h0;
            packet_sequence_id <= `RMC_SEQ_RESET;
        end else begin
            if (pushed)
                packet_sequence_id <= packet_sequence_id + 2'h1;
            if (drop)
                rd_ptr_reg <= ptr_inc(rd_ptr_reg);
            if (pushed && !drop)
                tx_count_reg <= tx_count_reg + 2'h1;
            else if (drop && !pushed)
                tx_count_reg <= tx_count_reg - 2'h1;
        end
    end

    // Set wins over a clear in the same cycle
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            delivered_flag      <= 1'b0;
            retry_limit_flag    <= 1'b0;
            lost_packet_counter <= 4'h0;
        end else begin
            if (drop)
                delivered_flag <= 1'b1;
            else if (clear_delivered)
                delivered_flag <= 1'b0;
            if (give_up)
                retry_limit_flag <= 1'b1;
            else if (clear_retry_limit)
                retry_limit_flag <= 1'b0;
            if (give_up && lost_packet_counter != 4'hF)
                lost_packet_counter <= lost_packet_counter + 4'h1;
            else if (channel_write)
                lost_packet_counter <= 4'h0;
        end
    end

    // Address for outgoing acks follows the arrival pipe
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            ack_address_reg <= 40'h0000000000;
        else if (ack_pipe == 3'h0)
            ack_address_reg <= pipe_zero_receive_address;
        else
            ack_address_reg <= {shared_upper, pipe_low_byte};
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_reg       <= `RMC_MODE_POWER_DOWN;
            send_start_reg <= 1'b0;
            send_len_reg   <= {LB{1'b0}};
            frame_wrap_reg <= 1'b0;
            retry_counter  <= 4'h0;
            wait_reg       <= 16'h0000;
        end else begin
            send_start_reg <= 1'b0;
            if (!power_on_bit) begin
                mode_reg       <= `RMC_MODE_POWER_DOWN;
                frame_wrap_reg <= 1'b0;
            end else begin
                case (mode_reg)
                `RMC_MODE_POWER_DOWN, `RMC_MODE_LOW_IDLE, `RMC_MODE_ARMED,
                `RMC_MODE_RECEIVE: begin
                    if (!pin_s)
                        mode_reg <= `RMC_MODE_LOW_IDLE;
                    else if (receive_role_bit)
                        mode_reg <= `RMC_MODE_RECEIVE;
                    else if (can_send) begin
                        mode_reg       <= `RMC_MODE_TRANSMIT;
                        send_start_reg <= 1'b1;
                        frame_wrap_reg <= 1'b1;
                        send_len_reg   <= len_mem[rd_ptr_reg];
                        retry_counter  <= 4'h0;
                    end else
                        mode_reg <= `RMC_MODE_ARMED;
                end
                `RMC_MODE_TRANSMIT: begin
                    if (send_done) begin
                        frame_wrap_reg <= 1'b0;
                        if (pipe_zero_auto_ack) begin
                            mode_reg <= `RMC_MODE_AWAIT_ACK;
                            wait_reg <= ACK_WAIT[15:0];
                        end else
                            mode_reg <= pin_s ? `RMC_MODE_ARMED : `RMC_MODE_LOW_IDLE;
                    end
                end
                `RMC_MODE_AWAIT_ACK: begin
                    if (wait_reg != 16'h0000)
                        wait_reg <= wait_reg - 16'h0001;
                    if (ack_ok)
                        mode_reg <= pin_s ? `RMC_MODE_ARMED : `RMC_MODE_LOW_IDLE;
                    else if (give_up)
                        mode_reg <= pin_s ? `RMC_MODE_ARMED : `RMC_MODE_LOW_IDLE;
                    else if (timeout) begin
                        mode_reg       <= `RMC_MODE_TRANSMIT;
                        send_start_reg <= 1'b1;
                        frame_wrap_reg <= 1'b1;
                        retry_counter  <= retry_counter + 4'h1;
                    end
                end
                default: mode_reg <= `RMC_MODE_POWER_DOWN;
                endcase
            end
        end
    end
endmodule // rmc_ctrl
`default_nettype wire

// ==== test/rmc_checker.sv ====
/* Port assertions for rmc_ctrl.
 Assumes bind onto rmc_ctrl; one clock, async low reset. */
`timescale 1ns/1ps
`default_nettype none
module rmc_checker (
    input wire logic       clk,          // Clock
    input wire logic       arst_n,       // Reset
    input wire logic       activate_pin, // Pin
    input wire logic       power_on_bit, // Power
    input wire logic       pipe_zero_auto_ack, // Auto-ack
    input wire logic       send_done,    // Radio done
    input wire logic       ack_valid,    // Ack seen
    input wire logic       channel_write, // Channel write
    input wire logic [2:0] mode_reg,     // Mode
    input wire logic       send_start_reg, // Send start
    input wire logic       delivered_flag, // Delivered
    input wire logic       retry_limit_flag, // Retry limit
    input wire logic [3:0] lost_packet_counter, // Lost
    input wire logic [1:0] tx_count_reg, // Queued
    input wire logic       load_ready,   // Room
    input wire logic       irq_n         // Interrupt
);
default clocking @(posedge clk); endclocking
default disable iff (!arst_n);
chk_pd_forced: assert property (!power_on_bit [*2] |-> mode_reg == 3'h0) else $error("not powered down");
chk_irq_flags: assert property (irq_n == !(delivered_flag || retry_limit_flag)) else $error("irq level");
chk_start_pulse: assert property (send_start_reg |=> !send_start_reg) else $error("start too long");
chk_no_send: assert property (retry_limit_flag |-> !send_start_reg) else $error("sent under limit");
chk_ack_listen: assert property (power_on_bit && send_done && mode_reg == 3'h3 && pipe_zero_auto_ack |=> mode_reg == 3'h4)
    else $error("no ack wait");
chk_ack_deliver: assert property (ack_valid && mode_reg == 3'h4 |=> delivered_flag) else $error("no delivered");
chk_lost_count: assert property ($rose(retry_limit_flag) |-> lost_packet_counter == $past(lost_packet_counter) + 4'h1)
    else $error("lost not counted");
chk_chan_clear: assert property (channel_write && mode_reg != 3'h4 |=> lost_packet_counter == 4'h0)
    else $error("lost not cleared");
chk_armed_idle: assert property ((mode_reg == 3'h2 && !activate_pin) ##1 !activate_pin [*3] |=> mode_reg != 3'h2)
    else $error("armed kept");
chk_room_flag: assert property (load_ready == (tx_count_reg != 2'h3)) else $error("room flag");
cov_deliver: cover property ($rose(delivered_flag));
cov_limit: cover property ($rose(retry_limit_flag));
cov_armed: cover property (mode_reg == 3'h2);
endmodule // rmc_checker
bind rmc_ctrl rmc_checker i_rmc_checker (.clk(clk), .arst_n(arst_n), .activate_pin(activate_pin),
    .power_on_bit(power_on_bit), .pipe_zero_auto_ack(pipe_zero_auto_ack), .send_done(send_done),
    .ack_valid(ack_valid), .channel_write(channel_write), .mode_reg(mode_reg), .send_start_reg(send_start_reg),
    .delivered_flag(delivered_flag), .retry_limit_flag(retry_limit_flag), .lost_packet_counter(lost_packet_counter),
    .tx_count_reg(tx_count_reg), .load_ready(load_ready), .irq_n(irq_n));
`default_nettype wire

// ==== test/rmc_radio_model.sv ====
/* Radio front end model: finishes a send, then maybe acks.
 Assumes one-cycle send start pulses on clk. */
`timescale 1ns/1ps
`default_nettype none
module rmc_radio_model (
    input wire logic  clk,        // Clock
    input wire logic  arst_n,     // Reset
    input wire logic  send_start, // Send request
    input wire logic  ack_en,     // Peer answers
    output var logic  send_done,  // Packet sent
    output var logic  ack_valid   // Ack arrived
);
logic [3:0] cnt;
always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
        cnt <= 4'h0;
        send_done <= 1'b0;
        ack_valid <= 1'b0;
    end else begin
        send_done <= (cnt == 4'h5);
        ack_valid <= (cnt == 4'h9) && ack_en;
        cnt <= send_start ? 4'h1 : (cnt != 4'h0 && cnt != 4'h9) ? cnt + 4'h1 : 4'h0;
    end
end
endmodule // rmc_radio_model
`default_nettype wire

// ==== test/tb_rmc_ctrl.sv ====
/* Self-checking bench for rmc_ctrl.
 Assumes the radio model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module tb_rmc_ctrl;
logic clk = 0, arst_n = 0, pin = 0, pwr = 0, role = 0, aa = 1, ack_en = 1;
logic ls = 0, lb = 0, le = 0, cd = 0, cr = 0, cw = 0;
logic [3:0] lim = 4'h2;
logic [2:0] ap = 3'h0;
wire logic sd, av, ss, fw, df, rf, lr, irq;
wire logic [2:0] md;
wire logic [5:0] len;
wire logic [1:0] sid, tc;
wire logic [39:0] aadr;
wire logic [3:0] rc, lc;
integer miscompares = 0, n_tests = 0;
always #20 clk = ~clk;
rmc_ctrl #(.ACK_WAIT(8)) i_rmc_ctrl (.clk(clk), .arst_n(arst_n), .activate_pin(pin), .power_on_bit(pwr),
    .receive_role_bit(role), .pipe_zero_auto_ack(aa), .retry_limit(lim), .load_start(ls), .load_byte(lb),
    .load_end(le), .clear_delivered(cd), .clear_retry_limit(cr), .channel_write(cw), .send_done(sd),
    .ack_valid(av), .pipe_zero_receive_address(40'h1122334455), .ack_pipe(ap), .pipe_low_byte(8'hC4),
    .shared_upper(32'hA0A1A2A3), .mode_reg(md), .send_start_reg(ss), .send_len_reg(len),
    .packet_sequence_id(sid), .frame_wrap_reg(fw), .ack_address_reg(aadr), .delivered_flag(df),
    .retry_limit_flag(rf), .retry_counter(rc), .lost_packet_counter(lc), .tx_count_reg(tc),
    .load_ready(lr), .irq_n(irq));
rmc_radio_model i_rmc_radio_model (.clk(clk), .arst_n(arst_n), .send_start(ss), .ack_en(ack_en),
    .send_done(sd), .ack_valid(av));
task tick; begin @(posedge clk); #1; end endtask
task summarize; begin
    $display("tests %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
end endtask
task cmp(input logic [39:0] g, input logic [39:0] e); begin
    n_tests++;
    if (g !== e) begin miscompares++; $display("[ERR] %0t got %h expected %h", $time, g, e); end
end endtask
task wu(input integer k, input logic [2:0] m); integer i; begin
    for (i = 0; i < 400 && !(k == 0 ? md === m : k == 1 ? df === 1'b1 : rf === 1'b1); i++) tick;
    if (i == 400) begin miscompares++; $display("[ERR] %0t wait ran out", $time); summarize; end
end endtask
task load(input integer n); integer i; begin
    ls = 1; tick; ls = 0;
    for (i = 0; i < n; i++) begin lb = 1; tick; end
    lb = 0; le = 1; tick; le = 0; tick;
end endtask
initial begin
    repeat (8) @(posedge clk);
    #1 arst_n = 1;
    tick;
    cmp(irq, 1);
    cmp(md, 0);
    load(4);
    cmp(tc, 1);
    cmp(sid, 1);
    pwr = 1; wu(0, 1);
    pin = 1; wu(0, 3);
    cmp(len, 4);
    cmp(fw, 1);
    wu(1, 0); tick;
    cmp(tc, 0);
    cmp(irq, 0);
    wu(0, 2);
    cd = 1; tick; cd = 0; tick;
    cmp(irq, 1);
    repeat (250) tick;
    pin = 0; wu(0, 1);
    ack_en = 0; load(3);
    cmp(sid, 2);
    pin = 1; wu(2, 0); tick;
    cmp(rc, lim);
    cmp(lc, 1);
    repeat (40) tick;
    cmp(tc, 1);
    cw = 1; tick; cw = 0; tick;
    cmp(lc, 0);
    ack_en = 1; cr = 1; tick; cr = 0; wu(1, 0); tick;
    cmp(tc, 0);
    cmp(rc, 0);
    cd = 1; tick; cd = 0; role = 1; wu(0, 5);
    ap = 3'h3; tick; tick;
    cmp(aadr, {32'hA0A1A2A3, 8'hC4});
    ap = 3'h0; tick; tick;
    cmp(aadr, 40'h1122334455);
    pwr = 0; tick; tick;
    cmp(md, 0);
    summarize;
end
endmodule // tb_rmc_ctrl
`default_nettype wire
